// *** rtl/dmu_multiblock.v ***
// Notes on behaviour
// - A transfer runs as one block or as a chain of several blocks.
// - Between blocks addresses come from descriptor, initial value, or continue on.
// - Control word is refreshed only by descriptor fetch or reload.
// - Link pointer is refreshed from memory whenever the next address is nonzero, whatever the chain enables.
// - A descriptor is four words: source, destination, link, control.
// - Chaining fetches the next descriptor before each block starts.
// - Link pointer holds the memory address of the next descriptor.
// - Zero next address, no chain, no reload: last block, no update.
// - Only destination reload: source continues, destination reloads.
// - Only source reload: source reloads, destination continues.
// - A zero next address on a non-last block restores control and link pointer initial values.
// - Chained modes load control and link from the next descriptor.
// - Destination chain only: source continues, destination from descriptor.
// - Destination chain with source reload: source reloads, destination fetched.
// - Source chain only: source fetched, destination continues.
// - Source chain with destination reload: source fetched, destination reloads.
// - Both chain enables: both addresses come from each descriptor.
// - Each block end evaluates the mode and ends on the last-block setting.
// - Reload modes with block flag enabled and unmasked stall until cleared.
// - Chained modes without reload go straight to the next block.
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "dmu_defs.vh"

module dmu_multiblock (
	input wire clk_i,
	input wire reset_n_i,
	input wire [7:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	input wire [3:0] avs_byteenable_i,
	output reg [31:0] avs_readdata_o,
	output reg avs_waitrequest_o,
	output reg [31:0] avm_address_o,
	output reg avm_read_o,
	input wire [31:0] avm_readdata_i,
	input wire avm_waitrequest_i,
	output reg beat_req_o,
	output wire [31:0] beat_src_addr_o,
	output wire [31:0] beat_dst_addr_o,
	input wire beat_ack_i,
	output reg busy_o,
	output reg block_end_o,
	output reg xfer_done_o
);

	localparam S_IDLE = 5'h01;
	localparam S_FETCH = 5'h02;
	localparam S_RUN = 5'h04;
	localparam S_EVAL = 5'h08;
	localparam S_STALL = 5'h10;

	reg [4:0] state_q;
	reg [31:0] src_q;
	reg [31:0] dst_q;
	reg [31:0] link_q;
	reg [31:0] ctl_q;
	reg [31:0] cfg_q;
	reg [31:0] src_init_q;
	reg [31:0] dst_init_q;
	reg [31:0] link_init_q;
	reg [31:0] ctl_init_q;
	reg mask_q;
	reg flag_q;
	reg next_fetch_q;
	reg fetch_src_q;
	reg fetch_dst_q;
	reg [1:0] fidx_q;
	reg [11:0] cnt_q;
	reg [31:0] rd_mux;
	wire [31:0] src_step;
	wire [31:0] dst_step;
	wire bus_req;
	wire bus_acc;
	wire wr_en;
	wire [31:0] wr_data;
	wire start_cmd;
	wire clr_cmd;
	wire next_item_zero;
	wire any_reload;
	wire last_block;
	wire stall_on;
	wire flag_set;
	wire last_beat;
	wire fetch_acc;

	// Merge a bus write into an old word, one byte lane at a time.
	function [31:0] be_merge;
		input [31:0] old_w;
		input [31:0] new_w;
		input [3:0] be;
		integer i;
		begin
			be_merge = old_w;
			for (i = 0; i < 4; i = i + 1)
			begin
				if (be[i])
					be_merge[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
	endfunction

	// Beat addresses are the live channel registers themselves.
	assign beat_src_addr_o = src_q;
	assign beat_dst_addr_o = dst_q;

	// Next beat addresses follow the programmed increment direction.
	dmu_addr_next u_src_next (
		.addr_i(src_q),
		.inc_mode_i(ctl_q[`DMU_CTL_SSTEP_HI:`DMU_CTL_SSTEP_LO]),
		.addr_o(src_step)
	);

	dmu_addr_next u_dst_next (
		.addr_i(dst_q),
		.inc_mode_i(ctl_q[`DMU_CTL_DSTEP_HI:`DMU_CTL_DSTEP_LO]),
		.addr_o(dst_step)
	);

	// Bus handshake: a request is answered exactly one cycle after it is first seen.
	assign bus_req = avs_read_i | avs_write_i;
	assign bus_acc = bus_req & ~avs_waitrequest_o;
	assign wr_en = avs_write_i & bus_acc;
	assign wr_data = avs_writedata_i;
	assign start_cmd = wr_en & (avs_address_i == `DMU_OFF_CMD) & avs_byteenable_i[0]
		& wr_data[`DMU_CMD_START];
	assign clr_cmd = wr_en & (avs_address_i == `DMU_OFF_CLR) & avs_byteenable_i[0]
		& wr_data[`DMU_CLR_BLOCK];

	// Mode decode for the block that has just finished.
	assign next_item_zero = (link_q[`DMU_NEXT_ITEM_HI:`DMU_NEXT_ITEM_LO] == `DMU_NEXT_ITEM_ZERO);
	assign any_reload = cfg_q[`DMU_CFG_SRC_RELOAD] | cfg_q[`DMU_CFG_DST_RELOAD];
	assign last_block = next_item_zero & ~ctl_q[`DMU_CTL_SRC_CHAIN]
		& ~ctl_q[`DMU_CTL_DST_CHAIN] & ~any_reload;
	assign flag_set = (state_q == S_EVAL) & ctl_q[`DMU_CTL_IRQ_EN] & ~mask_q;
	assign stall_on = any_reload & ctl_q[`DMU_CTL_IRQ_EN] & ~mask_q;
	assign last_beat = ((cnt_q + 12'h1) >= ctl_q[`DMU_CTL_BLK_HI:`DMU_CTL_BLK_LO]);
	assign fetch_acc = avm_read_o & ~avm_waitrequest_i;

	// Read multiplexer; unmapped offsets read as zero.
	always @*
	begin
		rd_mux = 32'h0;
		case (avs_address_i)
			`DMU_OFF_SRC: rd_mux = src_q;
			`DMU_OFF_DST: rd_mux = dst_q;
			`DMU_OFF_LINK: rd_mux = link_q;
			`DMU_OFF_CTL: rd_mux = ctl_q;
			`DMU_OFF_CFG: rd_mux = cfg_q;
			`DMU_OFF_CMD:
			begin
				rd_mux[4:0] = state_q;
				rd_mux[`DMU_STAT_FLAG] = flag_q;
				rd_mux[`DMU_STAT_BUSY] = busy_o;
			end
			`DMU_OFF_MASK: rd_mux[`DMU_MASK_BLOCK] = mask_q;
			default: rd_mux = 32'h0;
		endcase
	end

	// Slave answer registers; waitrequest idles high so no request is taken blind.
	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= `DMU_RST_WORD;
		end
		else if (bus_acc)
		begin
			avs_waitrequest_o <= 1'b1;
		end
		else if (bus_req)
		begin
			avs_waitrequest_o <= 1'b0;
			avs_readdata_o <= rd_mux;
		end
	end

	// Block flag: a new block end in the same cycle as a clear keeps the flag set.
	always @(posedge clk_i)
	begin
		if (!reset_n_i)
			flag_q <= 1'b0;
		else if (flag_set)
			flag_q <= 1'b1;
		else if (clr_cmd)
			flag_q <= 1'b0;
	end

	// Channel registers and the sequencer. Software writes come first so that
	// hardware updates in the same cycle take precedence; reload bits stay
	// writable while running because the end-of-block service must clear them.
	always @(posedge clk_i)
	begin
		if (!reset_n_i)
		begin
			state_q <= S_IDLE;
			src_q <= `DMU_RST_WORD;
			dst_q <= `DMU_RST_WORD;
			link_q <= `DMU_RST_WORD;
			ctl_q <= `DMU_RST_WORD;
			cfg_q <= `DMU_RST_WORD;
			src_init_q <= `DMU_RST_WORD;
			dst_init_q <= `DMU_RST_WORD;
			link_init_q <= `DMU_RST_WORD;
			ctl_init_q <= `DMU_RST_WORD;
			mask_q <= `DMU_RST_MASK;
			next_fetch_q <= 1'b0;
			fetch_src_q <= 1'b0;
			fetch_dst_q <= 1'b0;
			fidx_q <= 2'h0;
			cnt_q <= 12'h0;
			avm_address_o <= `DMU_RST_WORD;
			avm_read_o <= 1'b0;
			beat_req_o <= 1'b0;
			busy_o <= 1'b0;
			block_end_o <= 1'b0;
			xfer_done_o <= 1'b0;
		end
		else
		begin
			block_end_o <= 1'b0;
			xfer_done_o <= 1'b0;
			// Software writes also capture the initial values used by reload.
			if (wr_en)
			begin
				case (avs_address_i)
					`DMU_OFF_SRC:
					begin
						src_q <= be_merge(src_q, wr_data, avs_byteenable_i);
						src_init_q <= be_merge(src_q, wr_data, avs_byteenable_i);
					end
					`DMU_OFF_DST:
					begin
						dst_q <= be_merge(dst_q, wr_data, avs_byteenable_i);
						dst_init_q <= be_merge(dst_q, wr_data, avs_byteenable_i);
					end
					`DMU_OFF_LINK:
					begin
						link_q <= be_merge(link_q, wr_data, avs_byteenable_i);
						link_init_q <= be_merge(link_q, wr_data, avs_byteenable_i);
					end
					`DMU_OFF_CTL:
					begin
						ctl_q <= be_merge(ctl_q, wr_data, avs_byteenable_i);
						ctl_init_q <= be_merge(ctl_q, wr_data, avs_byteenable_i);
					end
					`DMU_OFF_CFG: cfg_q <= be_merge(cfg_q, wr_data, avs_byteenable_i);
					`DMU_OFF_MASK:
					begin
						if (avs_byteenable_i[0])
							mask_q <= wr_data[`DMU_MASK_BLOCK];
					end
					default: mask_q <= mask_q;
				endcase
			end
			case (state_q)
				S_IDLE:
				begin
					if (start_cmd)
					begin
						busy_o <= 1'b1;
						cnt_q <= 12'h0;
						if (!next_item_zero)
						begin
							// First descriptor sits at the programmed link address.
							fetch_src_q <= ctl_q[`DMU_CTL_SRC_CHAIN];
							fetch_dst_q <= ctl_q[`DMU_CTL_DST_CHAIN];
							fidx_q <= 2'h0;
							avm_address_o <= link_q;
							avm_read_o <= 1'b1;
							state_q <= S_FETCH;
						end
						else
						begin
							beat_req_o <= 1'b1;
							state_q <= S_RUN;
						end
					end
				end
				S_FETCH:
				begin
					// Words arrive in order: source, destination, link, control.
					if (fetch_acc)
					begin
						case (fidx_q)
							2'h0:
							begin
								if (fetch_src_q)
									src_q <= avm_readdata_i;
							end
							2'h1:
							begin
								if (fetch_dst_q)
									dst_q <= avm_readdata_i;
							end
							2'h2: link_q <= avm_readdata_i;
							default: ctl_q <= avm_readdata_i;
						endcase
						if (fidx_q == `DMU_DESC_LAST)
						begin
							avm_read_o <= 1'b0;
							cnt_q <= 12'h0;
							beat_req_o <= 1'b1;
							state_q <= S_RUN;
						end
						else
						begin
							fidx_q <= fidx_q + 2'h1;
							avm_address_o <= avm_address_o + `DMU_DESC_STEP;
						end
					end
				end
				S_RUN:
				begin
					if (beat_req_o && beat_ack_i)
					begin
						src_q <= src_step;
						dst_q <= dst_step;
						if (last_beat)
						begin
							beat_req_o <= 1'b0;
							block_end_o <= 1'b1;
							state_q <= S_EVAL;
						end
						else
							cnt_q <= cnt_q + 12'h1;
					end
				end
				S_EVAL:
				begin
					if (last_block)
					begin
						busy_o <= 1'b0;
						xfer_done_o <= 1'b1;
						state_q <= S_IDLE;
					end
					else
					begin
						// Addresses not reloaded or fetched keep their advanced value.
						if (cfg_q[`DMU_CFG_SRC_RELOAD])
							src_q <= src_init_q;
						if (cfg_q[`DMU_CFG_DST_RELOAD])
							dst_q <= dst_init_q;
						if (next_item_zero)
						begin
							ctl_q <= ctl_init_q;
							link_q <= link_init_q;
						end
						fetch_src_q <= ctl_q[`DMU_CTL_SRC_CHAIN];
						fetch_dst_q <= ctl_q[`DMU_CTL_DST_CHAIN];
						next_fetch_q <= ~next_item_zero;
						cnt_q <= 12'h0;
						fidx_q <= 2'h0;
						avm_address_o <= link_q;
						if (stall_on)
							state_q <= S_STALL;
						else if (!next_item_zero)
						begin
							avm_read_o <= 1'b1;
							state_q <= S_FETCH;
						end
						else
						begin
							beat_req_o <= 1'b1;
							state_q <= S_RUN;
						end
					end
				end
				S_STALL:
				begin
					// Held until software clears the block flag.
					if (!flag_q)
					begin
						if (next_fetch_q)
						begin
							avm_read_o <= 1'b1;
							state_q <= S_FETCH;
						end
						else
						begin
							beat_req_o <= 1'b1;
							state_q <= S_RUN;
						end
					end
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

endmodule // dmu_multiblock

// *** rtl/dmu_defs.vh ***
`ifndef DMU_DEFS_VH
`define DMU_DEFS_VH

// Register byte offsets on the Avalon-MM slave.
`define DMU_OFF_SRC 8'h00
`define DMU_OFF_DST 8'h04
`define DMU_OFF_LINK 8'h08
`define DMU_OFF_CTL 8'h0c
`define DMU_OFF_CFG 8'h10
`define DMU_OFF_CMD 8'h14
`define DMU_OFF_CLR 8'h18
`define DMU_OFF_MASK 8'h1c

// Channel control word fields.
`define DMU_CTL_IRQ_EN 0
`define DMU_CTL_SRC_CHAIN 1
`define DMU_CTL_DST_CHAIN 2
`define DMU_CTL_SSTEP_LO 3
`define DMU_CTL_SSTEP_HI 4
`define DMU_CTL_DSTEP_LO 5
`define DMU_CTL_DSTEP_HI 6
`define DMU_CTL_BLK_LO 16
`define DMU_CTL_BLK_HI 27

// Channel configuration word fields.
`define DMU_CFG_SRC_RELOAD 0
`define DMU_CFG_DST_RELOAD 1

// Next item address field of the link pointer.
`define DMU_NEXT_ITEM_LO 2
`define DMU_NEXT_ITEM_HI 31
`define DMU_NEXT_ITEM_ZERO 30'h0

// Command, clear, mask and status bits.
`define DMU_CMD_START 0
`define DMU_CLR_BLOCK 0
`define DMU_MASK_BLOCK 0
`define DMU_STAT_FLAG 8
`define DMU_STAT_BUSY 9

// Address increment encodings.
`define DMU_INC_UP 2'h0
`define DMU_INC_DOWN 2'h1

// Bytes moved per beat and descriptor stride.
`define DMU_BEAT_BYTES 32'h4
`define DMU_DESC_STEP 32'h4
`define DMU_DESC_LAST 2'h3

// Reset values.
`define DMU_RST_WORD 32'h0
`define DMU_RST_MASK 1'b0

`endif

// *** rtl/dmu_addr_next.v ***
`timescale 1ns/1ps
`include "dmu_defs.vh"

// Address of the beat after the current one, for one address channel.
module dmu_addr_next (
	input wire [31:0] addr_i,
	input wire [1:0] inc_mode_i,
	output reg [31:0] addr_o
);

	// Fixed addresses hold, so a peripheral port is hit on every beat.
	always @*
	begin
		case (inc_mode_i)
			`DMU_INC_UP: addr_o = addr_i + `DMU_BEAT_BYTES;
			`DMU_INC_DOWN: addr_o = addr_i - `DMU_BEAT_BYTES;
			default: addr_o = addr_i;
		endcase
	end

endmodule // dmu_addr_next

// *** tb/dmu_asserts.sv ***
`timescale 1ns/1ps
// Watches the register bus, descriptor master and beat port of the sequencer.
module dmu_asserts (
	input wire clk_i,
	input wire reset_n_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire avs_waitrequest_o,
	input wire [31:0] avm_address_o,
	input wire avm_read_o,
	input wire avm_waitrequest_i,
	input wire beat_req_o,
	input wire [31:0] beat_src_addr_o,
	input wire [31:0] beat_dst_addr_o,
	input wire beat_ack_i,
	input wire busy_o,
	input wire block_end_o,
	input wire xfer_done_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// Bus answers, descriptor stepping, beat holding and block end ordering.
	bus_answer_a: assert property (
		$rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
		else $error("register request not answered after one cycle");
	bus_pulse_a: assert property (
		$fell(avs_waitrequest_o) |=> avs_waitrequest_o)
		else $error("waitrequest low for more than one cycle");
	fetch_hold_a: assert property (
		avm_read_o && avm_waitrequest_i |=> avm_read_o && $stable(avm_address_o))
		else $error("descriptor read dropped or moved while stalled");
	fetch_step_a: assert property (
		avm_read_o && !avm_waitrequest_i ##1 avm_read_o
		|-> avm_address_o == $past(avm_address_o) + 32'h4)
		else $error("descriptor word address did not step by four");
	fetch_quiet_a: assert property (
		avm_read_o |-> !beat_req_o)
		else $error("beat requested during descriptor fetch");
	beat_hold_a: assert property (
		beat_req_o && !beat_ack_i
		|=> beat_req_o && $stable(beat_src_addr_o) && $stable(beat_dst_addr_o))
		else $error("beat request changed before acknowledge");
	done_after_end_a: assert property (
		xfer_done_o |-> $past(block_end_o))
		else $error("transfer ended without a block end before it");
	done_idle_a: assert property (
		xfer_done_o |=> !busy_o && !xfer_done_o)
		else $error("channel still busy after transfer end");
	end_pulse_a: assert property (
		block_end_o |-> !beat_req_o ##1 !block_end_o)
		else $error("block end not a single cycle after the last beat");
	beat_busy_a: assert property (
		beat_req_o |-> busy_o)
		else $error("beat requested while idle");
endmodule // dmu_asserts

// *** tb/dmu_mem_model.sv ***
`timescale 1ns/1ps
// Descriptor memory and beat sink with a fixed stall pattern.
module dmu_mem_model (
	input wire clk_i,
	input wire reset_n_i,
	input wire [31:0] avm_address_i,
	input wire avm_read_i,
	output logic [31:0] avm_readdata_o,
	output logic avm_waitrequest_o,
	input wire beat_req_i,
	output logic beat_ack_o
);
	logic [31:0] mem [0:31];
	logic [3:0] cnt_q;

	// Free-running count that paces both answers.
	always @(posedge clk_i)
		cnt_q <= reset_n_i ? cnt_q + 4'h1 : 4'h0;

	// Four prompt cycles then four stalled; data is inverted off the accepting cycle.
	always @*
	begin
		avm_waitrequest_o = cnt_q[2];
		avm_readdata_o = mem[avm_address_i[6:2]] ^ {32{avm_waitrequest_o}};
	end

	// Beats are taken on three cycles in four, so some blocks run slow.
	always @*
		beat_ack_o = beat_req_i && cnt_q[1:0] != 2'h3;
endmodule // dmu_mem_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`include "dmu_defs.vh"
module testbench;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [7:0] avs_address_i = 8'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o, avm_address_o, avm_readdata_i, beat_src_addr_o, beat_dst_addr_o;
	logic avs_waitrequest_o, avm_read_o, avm_waitrequest_i, beat_req_o, beat_ack_i;
	logic busy_o, block_end_o, xfer_done_o;
	int mismatches = 0;
	int cmp_count = 0;
	logic [31:0] rnd_q = 32'h59;
	logic [63:0] exp_q [$];
	logic [31:0] rd, s, d, sb, db, ln, ctl;
	logic [4:0] c;
	// Each entry: link nonzero, dst and src chain enables, dst and src reload.
	logic [4:0] cases [9] = '{5'h00, 5'h02, 5'h01, 5'h03, 5'h18, 5'h19, 5'h14, 5'h16, 5'h1c};

	dmu_multiblock dut (.clk_i, .reset_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
		.avm_address_o, .avm_read_o, .avm_readdata_i, .avm_waitrequest_i, .beat_req_o,
		.beat_src_addr_o, .beat_dst_addr_o, .beat_ack_i, .busy_o, .block_end_o, .xfer_done_o);
	dmu_mem_model mem_m (.clk_i, .reset_n_i, .avm_address_i(avm_address_o),
		.avm_read_i(avm_read_o), .avm_readdata_o(avm_readdata_i),
		.avm_waitrequest_o(avm_waitrequest_i), .beat_req_i(beat_req_o), .beat_ack_o(beat_ack_i));

	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One Avalon cycle, held until waitrequest is sampled low.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		avs_address_i <= a;
		avs_writedata_i <= v;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Two beats per block: source steps up, destination steps down.
	task automatic push(input logic [31:0] a, input logic [31:0] b);
		exp_q.push_back({a, b});
		exp_q.push_back({a + 32'h4, b - 32'h4});
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// The clock toggles every half period of 12.5 ns.
	initial
		forever #12.5 clk_i = ~clk_i;

	// Each accepted beat takes the oldest expected address pair.
	always @(posedge clk_i)
		if (reset_n_i && beat_req_o && beat_ack_i)
			check({beat_src_addr_o, beat_dst_addr_o}, exp_q.size() ? exp_q.pop_front() : 64'h0);

	// A hang is cut short well past the expected run length.
	initial
	begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		stop_test();
	end

	// Walks the table of update modes; software keeps to the legal rows only.
	initial
	begin
		mem_m.mem[16] = 32'h1000;
		mem_m.mem[17] = 32'h2000;
		mem_m.mem[18] = 32'h50;
		mem_m.mem[20] = 32'h3000;
		mem_m.mem[21] = 32'h4000;
		mem_m.mem[22] = 32'h0;
		mem_m.mem[23] = 32'h0002_0021;
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
		bus(1'b0, `DMU_OFF_SRC, 32'h0);
		check({32'h0, rd}, {32'h0, `DMU_RST_WORD});
		bus(1'b0, 8'h20, 32'h0);
		check({32'h0, rd}, 64'h0);
		foreach (cases[i])
		begin
			c = cases[i];
			rnd_q = xs(rnd_q);
			s = rnd_q & 32'h00ff_fff0;
			d = s ^ 32'h0100_0000;
			ln = c[4] ? 32'h40 : 32'h0;
			ctl = 32'h0002_0021 | {29'h0, c[3:2], 1'b0};
			mem_m.mem[19] = ctl;
			sb = (c[4] && c[2]) ? 32'h1000 : s;
			db = (c[4] && c[3]) ? 32'h2000 : d;
			push(sb, db);
			if (c != 5'h00)
			begin
				sb = (c[4] && c[2]) ? 32'h3000 : c[0] ? s : sb + 32'h8;
				db = (c[4] && c[3]) ? 32'h4000 : c[1] ? d : db - 32'h8;
				push(sb, db);
			end
			bus(1'b1, `DMU_OFF_CLR, 32'h1);
			bus(1'b1, `DMU_OFF_SRC, s);
			bus(1'b1, `DMU_OFF_DST, d);
			bus(1'b1, `DMU_OFF_LINK, ln);
			bus(1'b1, `DMU_OFF_CTL, ctl);
			bus(1'b1, `DMU_OFF_CFG, {30'h0, c[1:0]});
			bus(1'b1, `DMU_OFF_CMD, 32'h1);
			if (c[1:0] != 2'h0)
			begin
				do @(posedge clk_i); while (block_end_o !== 1'b1);
				repeat (6) @(posedge clk_i);
				check({63'h0, beat_req_o}, 64'h0);
				bus(1'b0, `DMU_OFF_CMD, 32'h0);
				check({32'h0, rd & 32'h3ff}, 64'h310);
				bus(1'b1, `DMU_OFF_CFG, 32'h0);
				bus(1'b1, `DMU_OFF_CLR, 32'h1);
			end
			do @(posedge clk_i); while (xfer_done_o !== 1'b1);
			check(64'(exp_q.size()), 64'h0);
		end
		// Masked flag: a double reload run neither stalls nor raises the flag.
		bus(1'b1, `DMU_OFF_MASK, 32'h1);
		bus(1'b0, `DMU_OFF_MASK, 32'h0);
		check({32'h0, rd}, 64'h1);
		bus(1'b1, `DMU_OFF_CLR, 32'h1);
		bus(1'b1, `DMU_OFF_SRC, s);
		bus(1'b1, `DMU_OFF_DST, d);
		bus(1'b1, `DMU_OFF_LINK, 32'h0);
		bus(1'b1, `DMU_OFF_CTL, 32'h0002_0021);
		bus(1'b1, `DMU_OFF_CFG, 32'h3);
		push(s, d);
		push(s, d);
		bus(1'b1, `DMU_OFF_CMD, 32'h1);
		// The reload bits land while the second block still runs, so it is the last one.
		do @(posedge clk_i); while (block_end_o !== 1'b1);
		bus(1'b1, `DMU_OFF_CFG, 32'h0);
		do @(posedge clk_i); while (xfer_done_o !== 1'b1);
		bus(1'b0, `DMU_OFF_CMD, 32'h0);
		check({32'h0, rd & 32'h3ff}, 64'h1);
		check(64'(exp_q.size()), 64'h0);
		stop_test();
	end
endmodule // testbench

bind dmu_multiblock dmu_asserts chk (.clk_i, .reset_n_i, .avs_read_i, .avs_write_i,
	.avs_waitrequest_o, .avm_address_o, .avm_read_o, .avm_waitrequest_i, .beat_req_o,
	.beat_src_addr_o, .beat_dst_addr_o, .beat_ack_i, .busy_o, .block_end_o, .xfer_done_o);
